// [design/lgp_pkg.sv]
// Purpose: Shared constants and types for the LED grayscale PWM driver
// Assumes: 16 channels, 6-bit trim, 12-bit grayscale
// Notes:   Status packet layout and timing counts live here
package lgp_pkg;
	localparam int CHANNELS      = 16;
	localparam int TRIM_BITS     = 6;
	localparam int GRAY_BITS     = 12;
	localparam int TRIM_LEN      = CHANNELS * TRIM_BITS;
	localparam int GRAY_LEN      = CHANNELS * GRAY_BITS;
	localparam int STAT_OPEN_LO  = 0;
	localparam int STAT_OTEMP    = 16;
	localparam int STAT_TRIM_LO  = 24;
	localparam int STAT_TRIM_HI  = 119;
	localparam logic [11:0] GRAY_MAX   = 12'hfff;
	localparam logic [11:0] GRAY_RESET = 12'h000;
	localparam logic [5:0]  TRIM_RESET = 6'h00;
	// Timing
	localparam int CLK_PERIOD_NS   = 100;
	localparam int OPEN_DETECT_NS  = 1000;
	localparam int OPEN_DETECT_RAW = OPEN_DETECT_NS / CLK_PERIOD_NS;
	localparam logic [3:0] OPEN_DETECT_CYC =
		(OPEN_DETECT_RAW < 1) ? 4'h1 : 4'(OPEN_DETECT_RAW);
	localparam logic [3:0] OPEN_CNT_RESET = 4'h0;

	typedef enum logic [1:0] {
		PH_IDLE  = 2'b00,
		PH_LATCH = 2'b01,
		PH_EXTRA = 2'b10
	} lgp_phase_e;
endpackage

// [design/lgp_pwm_if.sv]
// Purpose: Carries grayscale words and channel states between domains
// Assumes: grayValue is stable whenever grayToggle changes
// Notes:   chanOn is owned by the count clock domain
`timescale 1ns/10ps
interface lgp_pwm_if;
	logic [lgp_pkg::GRAY_LEN-1:0] grayValue;
	logic                         grayToggle;
	logic [lgp_pkg::CHANNELS-1:0] chanOn;

	modport ctrl (
		output grayValue,
		output grayToggle,
		input  chanOn
	);
	modport pwm (
		input  grayValue,
		input  grayToggle,
		output chanOn
	);
endinterface

// [design/lgp_pwm_core.sv]
// Purpose: Grayscale PWM counter and channel switching
// Assumes: Runs on the count clock; blank and reset arrive from outside
// Notes:   Grayscale words taken over by toggle handshake
`timescale 1ns/10ps
module lgp_pwm_core (
	// Clock and reset
	input  wire logic pwmCountClock,
	input  wire logic sys_rst,
	// Blanking pin
	input  wire logic blankIn,
	// Link to control domain
	lgp_pwm_if.pwm    pif
);
	typedef struct packed {
		logic                             rstS1;
		logic                             rstS2;
		logic                             blankS1;
		logic                             blankS2;
		logic                             togS1;
		logic                             togS2;
		logic                             togSeen;
		logic [11:0]                      count;
		logic [lgp_pkg::CHANNELS-1:0]     lit;
		logic [lgp_pkg::GRAY_LEN-1:0]     gray;
	} lgp_pwm_s;

	lgp_pwm_s state_reg;
	lgp_pwm_s state_next;

	always_comb begin
		logic [11:0] nextCount;
		nextCount = state_reg.count;
		state_next = state_reg;
		state_next.rstS1   = sys_rst;
		state_next.rstS2   = state_reg.rstS1;
		state_next.blankS1 = blankIn;
		state_next.blankS2 = state_reg.blankS1;
		state_next.togS1   = pif.grayToggle;
		state_next.togS2   = state_reg.togS1;
		if (state_reg.togS2 != state_reg.togSeen) begin
			state_next.togSeen = state_reg.togS2;
			state_next.gray    = pif.grayValue;
		end
		if (state_reg.blankS2) begin
			state_next.count = lgp_pkg::GRAY_RESET;
			state_next.lit   = '0;
		end else if (state_reg.count != lgp_pkg::GRAY_MAX) begin
			nextCount = state_reg.count + 12'h001;
			state_next.count = nextCount;
			for (int i = 0; i < lgp_pkg::CHANNELS; i++) begin
				if (state_reg.count == lgp_pkg::GRAY_RESET)
					state_next.lit[i] =
						(state_reg.gray[i*12 +: 12] != 12'h000);
				if (state_reg.gray[i*12 +: 12] == nextCount)
					state_next.lit[i] = 1'b0;
			end
			if (nextCount == lgp_pkg::GRAY_MAX)
				state_next.lit = '0;
		end
		if (state_reg.rstS2) begin
			state_next.count   = lgp_pkg::GRAY_RESET;
			state_next.lit     = '0;
			state_next.gray    = '0;
			state_next.togSeen = 1'b0;
		end
	end

	always_ff @(posedge pwmCountClock) begin
		state_reg <= state_next;
	end

	assign pif.chanOn = state_reg.lit;
endmodule

// [design/lgp_driver.sv]
// Purpose: Serial front end, trim and grayscale latches, status readback
// Assumes: Serial pins are slow against clk; count clock is its own domain
// Notes:   Serial, sense and blank pins pass two flip-flops before use; sys_rst acts directly on clk logic
//
// Overview of operation
// - Mode high gives a 96-bit shift register feeding the trim register.
// - Mode low gives a 192-bit shift register feeding the grayscale register.
// - Trim packet is sixteen 6-bit values, MSB of channel 15 first.
// - Trim value scales channel current linearly in 64 steps.
// - Trim register is transparent while strobe high, holds while low.
// - New trim values act at once, no blanking needed.
// - Grayscale packet is sixteen 12-bit values, all updated together.
// - Grayscale active at strobe rise, or at the extra serial clock after a trim latch; controller latches while blanked.
// - After each grayscale update the shift register takes the status packet.
// - Status: open flags 0-15, overtemp 16, trim 24-119, rest reserved.
// - Serial output shows status MSB on load, then next bits per clock.
// - Open flag sets when a lit channel stays low past the detect delay.
// - Blank falling starts cycle; first count clock lights channels with values above 1.
// - Each count clock increments; channels equal to count switch off.
// - At the maximum count the counter stops and all outputs go off.
// - Blank resets the counter at once; controller blanks after 4096 clocks.
// - Blank high disables all channel outputs.
// - Serial data shifts in on rising serial clock, MSB first.
// - Error output pulled low on open LED or overtemperature.
// - Open flags captured into status when strobe falls.
`timescale 1ns/10ps
module lgp_driver #(
	// Open-LED detect delay in clk cycles
	parameter logic [3:0] OPEN_DELAY = lgp_pkg::OPEN_DETECT_CYC
) (
	// Clocks and reset
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	input  wire logic                         pwmCountClock,
	// Serial link pins
	input  wire logic                         serialClock,
	input  wire logic                         serialDataIn,
	input  wire logic                         latchStrobe,
	input  wire logic                         modeSelect,
	output logic                              serialDataOut,
	// Output control
	input  wire logic                         blankIn,
	output logic [lgp_pkg::CHANNELS-1:0]      channelSinkOutput,
	output logic [lgp_pkg::TRIM_LEN-1:0]      channelTrimLevel,
	// Error sensing
	input  wire logic [lgp_pkg::CHANNELS-1:0] channelLowIn,
	input  wire logic                         overtempIn,
	output logic [lgp_pkg::CHANNELS-1:0]      openLedFlag,
	output logic                              overtempFlag,
	output logic                              errorOdOut,
	output logic                              errorOdOe
);
	typedef struct packed {
		logic                             sclkS1;
		logic                             sclkS2;
		logic                             sclkS3;
		logic                             sinS1;
		logic                             sinS2;
		logic                             latS1;
		logic                             latS2;
		logic                             latS3;
		logic                             modeS1;
		logic                             modeS2;
		logic                             otS1;
		logic                             otS2;
		logic [lgp_pkg::CHANNELS-1:0]     lowS1;
		logic [lgp_pkg::CHANNELS-1:0]     lowS2;
		logic [lgp_pkg::CHANNELS-1:0]     onS1;
		logic [lgp_pkg::CHANNELS-1:0]     onS2;
		logic [lgp_pkg::GRAY_LEN-1:0]     shift;
		logic [lgp_pkg::TRIM_LEN-1:0]     trim;
		logic [lgp_pkg::GRAY_LEN-1:0]     gray;
		logic                             grayTog;
		logic [lgp_pkg::CHANNELS-1:0][3:0] openCnt;
		logic [lgp_pkg::CHANNELS-1:0]     openFlag;
		logic [lgp_pkg::CHANNELS-1:0]     openCaught;
		lgp_pkg::lgp_phase_e              phase;
		logic                             trimSinceGray;
		logic                             latchMode;
		logic                             serial_data_out;
		logic [lgp_pkg::TRIM_LEN-1:0]     trimLevel;
		logic                             errOe;
	} lgp_core_s;

	lgp_core_s state_reg;
	lgp_core_s state_next;

	lgp_pwm_if pif ();

	lgp_pwm_core u_pwm (
		.pwmCountClock (pwmCountClock),
		.sys_rst       (sys_rst),
		.blankIn       (blankIn),
		.pif           (pif.pwm)
	);

	// Shift one bit in, keeping only the active length
	function automatic logic [lgp_pkg::GRAY_LEN-1:0] shiftIn(
		input logic [lgp_pkg::GRAY_LEN-1:0] cur,
		input logic                         bitIn,
		input logic                         trimMode
	);
		logic [lgp_pkg::GRAY_LEN-1:0] res;
		res = {cur[lgp_pkg::GRAY_LEN-2:0], bitIn};
		if (trimMode)
			res[lgp_pkg::GRAY_LEN-1:lgp_pkg::TRIM_LEN] = '0;
		return res;
	endfunction

	// Most significant bit for the active length
	function automatic logic topBit(
		input logic [lgp_pkg::GRAY_LEN-1:0] cur,
		input logic                         trimMode
	);
		logic res;
		if (trimMode)
			res = cur[lgp_pkg::TRIM_LEN-1];
		else
			res = cur[lgp_pkg::GRAY_LEN-1];
		return res;
	endfunction

	// Assemble the readback packet
	function automatic logic [lgp_pkg::GRAY_LEN-1:0] statusPacket(
		input logic [lgp_pkg::CHANNELS-1:0] opens,
		input logic                         hot,
		input logic [lgp_pkg::TRIM_LEN-1:0] trimVal
	);
		logic [lgp_pkg::GRAY_LEN-1:0] res;
		res = '0;
		res[lgp_pkg::STAT_OPEN_LO +: lgp_pkg::CHANNELS] = opens;
		res[lgp_pkg::STAT_OTEMP] = hot;
		res[lgp_pkg::STAT_TRIM_HI:lgp_pkg::STAT_TRIM_LO] = trimVal;
		return res;
	endfunction

	// Rising edge between two synchroniser stages
	function automatic logic risen(
		input logic cur,
		input logic prev
	);
		return cur & ~prev;
	endfunction

	// Next open-detect count for one channel
	function automatic logic [3:0] openCount(
		input logic [3:0] cnt,
		input logic       lit,
		input logic       low
	);
		logic [3:0] res;
		res = lgp_pkg::OPEN_CNT_RESET;
		if (lit && low && cnt < OPEN_DELAY)
			res = cnt + 4'h1;
		else if (lit && low)
			res = cnt;
		return res;
	endfunction

	// Next open flag: set after the delay, cleared once lit and high
	function automatic logic openNext(
		input logic [3:0] cnt,
		input logic       flag,
		input logic       lit,
		input logic       low
	);
		logic res;
		res = flag;
		if (lit && low && cnt >= OPEN_DELAY)
			res = 1'b1;
		else if (lit && !low)
			res = 1'b0;
		return res;
	endfunction

	// Current level: trim while lit, zero while dark
	function automatic logic [lgp_pkg::TRIM_LEN-1:0] levelFor(
		input logic [lgp_pkg::CHANNELS-1:0] lit,
		input logic [lgp_pkg::TRIM_LEN-1:0] trimVal
	);
		logic [lgp_pkg::TRIM_LEN-1:0] res;
		res = '0;
		for (int i = 0; i < lgp_pkg::CHANNELS; i++) begin
			if (lit[i])
				res[i*6 +: 6] = trimVal[i*6 +: 6];
			else
				res[i*6 +: 6] = lgp_pkg::TRIM_RESET;
		end
		return res;
	endfunction

	// Error line pulled while any flag or overtemperature stands
	function automatic logic errorPull(
		input logic [lgp_pkg::CHANNELS-1:0] opens,
		input logic                         hot
	);
		return (|opens) | hot;
	endfunction

	always_comb begin
		logic sclkRise;
		logic latRise;
		logic latFall;
		logic doGray;
		logic [lgp_pkg::GRAY_LEN-1:0] stat;
		sclkRise = 1'b0;
		latRise  = 1'b0;
		latFall  = 1'b0;
		doGray   = 1'b0;
		stat     = '0;
		state_next = state_reg;

		// Pin synchronisers
		state_next.sclkS1 = serialClock;
		state_next.sclkS2 = state_reg.sclkS1;
		state_next.sclkS3 = state_reg.sclkS2;
		state_next.sinS1  = serialDataIn;
		state_next.sinS2  = state_reg.sinS1;
		state_next.latS1  = latchStrobe;
		state_next.latS2  = state_reg.latS1;
		state_next.latS3  = state_reg.latS2;
		state_next.modeS1 = modeSelect;
		state_next.modeS2 = state_reg.modeS1;
		state_next.otS1   = overtempIn;
		state_next.otS2   = state_reg.otS1;
		state_next.lowS1  = channelLowIn;
		state_next.lowS2  = state_reg.lowS1;
		state_next.onS1   = pif.chanOn;
		state_next.onS2   = state_reg.onS1;

		sclkRise = risen(state_reg.sclkS2, state_reg.sclkS3);
		latRise  = risen(state_reg.latS2, state_reg.latS3);
		latFall  = risen(state_reg.latS3, state_reg.latS2);

		// Shift register, idle while the strobe is high
		if (sclkRise && !state_reg.latS2) begin
			if (state_reg.phase == lgp_pkg::PH_EXTRA) begin
				doGray = 1'b1;
				state_next.phase = lgp_pkg::PH_IDLE;
			end else begin
				state_next.shift = shiftIn(state_reg.shift,
					state_reg.sinS2, state_reg.modeS2);
			end
		end

		// Level-sensitive latches
		if (state_reg.latS2) begin
			if (latRise) begin
				state_next.latchMode = state_reg.modeS2;
				state_next.phase     = lgp_pkg::PH_LATCH;
			end
			if (state_reg.modeS2) begin
				state_next.trim =
					state_reg.shift[lgp_pkg::TRIM_LEN-1:0];
			end else if (!state_reg.trimSinceGray) begin
				state_next.gray = state_reg.shift;
				if (latRise)
					state_next.grayTog = ~state_reg.grayTog;
			end
		end

		// Strobe release
		if (latFall) begin
			state_next.openCaught = state_reg.openFlag;
			if (state_reg.latchMode) begin
				state_next.trimSinceGray = 1'b1;
				state_next.phase         = lgp_pkg::PH_IDLE;
			end else if (state_reg.trimSinceGray) begin
				state_next.phase = lgp_pkg::PH_EXTRA;
			end else begin
				stat = statusPacket(state_reg.openFlag, state_reg.otS2,
					state_reg.trim);
				state_next.shift = stat;
				state_next.phase = lgp_pkg::PH_IDLE;
			end
		end

		// Delayed grayscale update after the extra serial clock
		if (doGray) begin
			state_next.gray          = state_reg.shift;
			state_next.grayTog       = ~state_reg.grayTog;
			state_next.trimSinceGray = 1'b0;
			stat = statusPacket(state_reg.openCaught, state_reg.otS2,
				state_reg.trim);
			state_next.shift = stat;
		end

		// Serial output follows the active top bit
		state_next.serial_data_out = topBit(state_next.shift, state_reg.modeS2);

		// Open-LED detection per channel
		for (int i = 0; i < lgp_pkg::CHANNELS; i++) begin
			state_next.openCnt[i] = openCount(state_reg.openCnt[i],
				state_reg.onS2[i], state_reg.lowS2[i]);
			state_next.openFlag[i] = openNext(state_reg.openCnt[i],
				state_reg.openFlag[i], state_reg.onS2[i],
				state_reg.lowS2[i]);
		end
		state_next.trimLevel = levelFor(state_reg.onS2,
			state_next.trim);

		// Error output
		state_next.errOe = errorPull(state_reg.openFlag,
			state_reg.otS2);

		if (sys_rst) begin
			state_next.shift         = '0;
			state_next.trim          = '0;
			state_next.gray          = '0;
			state_next.grayTog       = 1'b0;
			state_next.openCnt       = '0;
			state_next.openFlag      = '0;
			state_next.openCaught    = '0;
			state_next.phase         = lgp_pkg::PH_IDLE;
			state_next.trimSinceGray = 1'b0;
			state_next.latchMode     = 1'b0;
			state_next.serial_data_out          = 1'b0;
			state_next.trimLevel     = '0;
			state_next.errOe         = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		state_reg <= state_next;
	end

	// Link to the count clock domain
	assign pif.grayValue  = state_reg.gray;
	assign pif.grayToggle = state_reg.grayTog;

	// Outputs
	assign serialDataOut     = state_reg.serial_data_out;
	assign channelSinkOutput = pif.chanOn;
	assign channelTrimLevel  = state_reg.trimLevel;
	assign openLedFlag       = state_reg.openFlag;
	assign overtempFlag      = state_reg.otS2;
	assign errorOdOut        = 1'b0;
	assign errorOdOe         = state_reg.errOe;
endmodule

// [verif/lgp_ctrl_model.sv]
// Purpose: Controller model driving the serial chain
// Assumes: One serial bit every eleven clk cycles
// Notes:   Data line shows the inverse of the last bit when idle
`timescale 1ns/10ps
module lgp_ctrl_model (
	// Clock
	input  wire logic clk,
	// Serial chain
	input  wire logic serialDataOut,
	output logic      serialClock,
	output logic      serialDataIn,
	output logic      latchStrobe,
	output logic      modeSelect
);
	logic trimLast;

	initial begin
		serialClock = 1'b0;
		serialDataIn = 1'b0;
		latchStrobe = 1'b0;
		modeSelect = 1'b0;
		trimLast = 1'b0;
	end

	// One serial clock, high five cycles, then low four before returning
	task automatic pulse();
		@(posedge clk) serialClock <= 1'b1;
		repeat (5) @(posedge clk);
		serialClock <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic send(input logic [191:0] d, input int n,
		output logic [191:0] got);
		got = 192'h0;
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge clk) serialDataIn <= d[i];
			got[i] = serialDataOut;
			pulse();
		end
		@(posedge clk) serialDataIn <= ~serialDataIn;
	endtask

	task automatic setMode(input logic m);
		@(posedge clk) modeSelect <= m;
		repeat (4) @(posedge clk);
	endtask

	task automatic latch();
		repeat (4) @(posedge clk);
		latchStrobe <= 1'b1;
		repeat (7) @(posedge clk);
		latchStrobe <= 1'b0;
		repeat (6) @(posedge clk);
		if (!modeSelect && trimLast)
			pulse();
		trimLast = modeSelect;
		repeat (6) @(posedge clk);
	endtask
endmodule

// [verif/lgp_monitor.sv]
// Purpose: Port-level checks for the LED grayscale PWM driver
// Assumes: Two or three flops on each crossing
// Notes:   Blank-low count edges are counted for the end-of-count check
`timescale 1ns/10ps
module lgp_monitor (
	// Clocks and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        pwmCountClock,
	// Serial and blanking
	input wire logic        latchStrobe,
	input wire logic        serialDataOut,
	input wire logic        blankIn,
	// Outputs and errors
	input wire logic [15:0] channelSinkOutput,
	input wire logic [95:0] channelTrimLevel,
	input wire logic        overtempIn,
	input wire logic [15:0] openLedFlag,
	input wire logic        overtempFlag,
	input wire logic        errorOdOut,
	input wire logic        errorOdOe
);
	logic [12:0] lowCount_reg;
	logic [12:0] lowCount_next;
	logic        anyErr;

	assign anyErr = (|openLedFlag) | overtempFlag;
	assign lowCount_next = (sys_rst | blankIn) ? 13'h0000
		: lowCount_reg + {12'h000, ~&lowCount_reg};
	always_ff @(posedge pwmCountClock) begin
		lowCount_reg <= lowCount_next;
	end

	sequence s_blank_held;
		blankIn [*5];
	endsequence
	sequence s_err_held;
		anyErr [*2];
	endsequence
	sequence s_calm_held;
		!anyErr [*2];
	endsequence
	sequence s_strobe_held;
		latchStrobe [*6];
	endsequence

	a_blank_off: assert property (@(posedge pwmCountClock)
		disable iff (sys_rst) s_blank_held |-> channelSinkOutput == 16'h0000)
		else $error("outputs on while blanked");
	a_count_end_off: assert property (@(posedge pwmCountClock)
		disable iff (sys_rst) lowCount_reg > 13'h1010
		|-> channelSinkOutput == 16'h0000)
		else $error("outputs on after full count");
	a_err_set: assert property (@(posedge clk)
		disable iff (sys_rst) s_err_held |-> errorOdOe)
		else $error("error line not pulled");
	a_err_clear: assert property (@(posedge clk)
		disable iff (sys_rst) s_calm_held |-> !errorOdOe)
		else $error("error line pulled with no error");
	a_drive_low: assert property (@(posedge clk)
		disable iff (sys_rst) errorOdOe |-> errorOdOut == 1'b0)
		else $error("error line driven high");
	a_overtemp_flag: assert property (@(posedge clk)
		disable iff (sys_rst) overtempIn [*5] |-> overtempFlag)
		else $error("overtemp flag missing");
	a_strobe_hold: assert property (@(posedge clk)
		disable iff (sys_rst) s_strobe_held |-> $stable(serialDataOut))
		else $error("serial out moved while latched");
	a_trim_gate: assert property (@(posedge clk)
		disable iff (sys_rst) blankIn [*6] |-> channelTrimLevel == 96'h0)
		else $error("current level while blanked");
endmodule

bind lgp_driver lgp_monitor u_lgp_monitor (
	.clk, .sys_rst, .pwmCountClock, .latchStrobe, .serialDataOut,
	.blankIn, .channelSinkOutput, .channelTrimLevel, .overtempIn,
	.openLedFlag, .overtempFlag, .errorOdOut, .errorOdOe
);

// [verif/lgp_tb.sv]
// Purpose: Self-checking bench for the LED grayscale PWM driver
// Assumes: Controller model drives the serial pins
// Notes:   Gray classes make the lit set known mid-cycle
`timescale 1ns/10ps
module testbench;
	logic         clk = 1'b0;
	logic         sys_rst, pwmCountClock, blankIn, overtempIn;
	logic         serialClock, serialDataIn, latchStrobe, modeSelect;
	logic         serialDataOut, overtempFlag, errorOdOut, errorOdOe;
	logic [15:0]  channelSinkOutput, channelLowIn, openLedFlag, expOn;
	logic [95:0]  channelTrimLevel, trim, expLvl;
	logic [191:0] gray, got;
	int           failures, checksDone, cycles, k, r;

	always #50 clk = ~clk;
	initial begin
		pwmCountClock = 1'b0;
		#1.3;
		forever #3 pwmCountClock = ~pwmCountClock;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end

	task automatic check(input logic [191:0] seen, input logic [191:0] exp);
		checksDone++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		if (failures == 0 && checksDone > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	function automatic logic [191:0] stat(input logic [15:0] op,
		input logic ot, input logic [95:0] tr);
		stat = 192'h0;
		stat[15:0] = op;
		stat[16] = ot;
		stat[119:24] = tr;
	endfunction

	initial begin
		sys_rst = 1'b1;
		blankIn = 1'b1;
		overtempIn = 1'b0;
		channelLowIn = 16'h0000;
		k = $urandom(32'hd7b90a53);
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		check(serialDataOut, 1'b0);
		check(errorOdOe, 1'b0);
		k = $urandom % 16;
		for (int i = 0; i < 16; i++) begin
			r = (i == k) ? 2 : $urandom % 3;
			gray[i*12 +: 12] = (r == 0) ? 12'h000
				: (r == 1) ? 12'($urandom % 8 + 1) : 12'(12'h800 | $urandom);
			expOn[i] = (r == 2);
		end
		trim = {$urandom, $urandom, $urandom};
		u_lgp_ctrl_model.send(gray, 192, got);
		u_lgp_ctrl_model.latch();
		u_lgp_ctrl_model.setMode(1'b1);
		u_lgp_ctrl_model.send({96'h0, trim}, 96, got);
		u_lgp_ctrl_model.latch();
		u_lgp_ctrl_model.setMode(1'b0);
		u_lgp_ctrl_model.send(gray, 192, got);
		u_lgp_ctrl_model.latch();
		blankIn <= 1'b0;
		repeat (20) @(posedge clk);
		check(channelSinkOutput, expOn);
		for (int i = 0; i < 16; i++)
			expLvl[i*6 +: 6] = expOn[i] ? trim[i*6 +: 6] : 6'h00;
		check(channelTrimLevel, expLvl);
		channelLowIn[k] <= 1'b1;
		repeat (20) @(posedge clk);
		check(openLedFlag, 16'h0001 << k);
		check(errorOdOe, 1'b1);
		blankIn <= 1'b1;
		repeat (10) @(posedge clk);
		check(channelSinkOutput, 16'h0000);
		blankIn <= 1'b0;
		repeat (300) @(posedge clk);
		check(channelSinkOutput, 16'h0000);
		blankIn <= 1'b1;
		channelLowIn <= 16'h0000;
		overtempIn <= 1'b1;
		repeat (10) @(posedge clk);
		check(channelSinkOutput, 16'h0000);
		u_lgp_ctrl_model.send(gray, 192, got);
		check(got, stat(16'h0000, 1'b0, trim));
		u_lgp_ctrl_model.latch();
		u_lgp_ctrl_model.send(gray, 192, got);
		check(got, stat(16'h0001 << k, 1'b1, trim));
		check(errorOdOe, 1'b1);
		blankIn <= 1'b0;
		repeat (20) @(posedge clk);
		check(channelSinkOutput, expOn);
		print_verdict();
	end

	lgp_driver u_lgp_driver (
		.clk, .sys_rst, .pwmCountClock, .serialClock, .serialDataIn,
		.latchStrobe, .modeSelect, .serialDataOut, .blankIn,
		.channelSinkOutput, .channelTrimLevel, .channelLowIn, .overtempIn,
		.openLedFlag, .overtempFlag, .errorOdOut, .errorOdOe
	);
	lgp_ctrl_model u_lgp_ctrl_model (
		.clk, .serialDataOut, .serialClock, .serialDataIn, .latchStrobe,
		.modeSelect
	);
endmodule
